// [rtl/epc_pkg.sv]
// Shared constants for the encoder phase counter and waveform pin timer block.
package epc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH   = 6;
  localparam int CNT_W    = 16;
  localparam int ADDR_W   = 9;
  localparam int DATA_W   = 32;
  localparam int NUM_MR   = 4;
  localparam int CH_LSB   = 6;
  localparam int PS_DIV_W = 6;

  // ----------------------------------------------------------------
  // Register byte offsets inside one channel window (stride 0x40)
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_CTRL    = 6'h00;
  localparam logic [5:0] OFS_IOCTL   = 6'h04;
  localparam logic [5:0] OFS_COUNT   = 6'h08;
  localparam logic [5:0] OFS_MATCH_A = 6'h0c;
  localparam logic [5:0] OFS_MATCH_B = 6'h10;
  localparam logic [5:0] OFS_MATCH_C = 6'h14;
  localparam logic [5:0] OFS_MATCH_D = 6'h18;
  localparam logic [5:0] OFS_STATUS  = 6'h1c;
  localparam logic [5:0] OFS_MASK    = 6'h20;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CLR_LSB  = 4;
  localparam int CTRL_PS_LSB   = 8;
  localparam int CTRL_RUN_BIT  = 15;

  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_PWM1   = 3'h1;
  localparam logic [2:0] MODE_PWM2   = 3'h2;
  localparam int         MODE_PHASE_BIT = 2;

  localparam logic [1:0] SUB_PHASE1 = 2'h0;
  localparam logic [1:0] SUB_PHASE2 = 2'h1;
  localparam logic [1:0] SUB_PHASE3 = 2'h2;
  localparam logic [1:0] SUB_PHASE4 = 2'h3;

  localparam logic [1:0] CLR_NONE = 2'h0;

  // ----------------------------------------------------------------
  // Pin action fields, four bits per pin inside the I/O control register
  // ----------------------------------------------------------------
  localparam int         IO_FIELD_W  = 4;
  localparam int         IO_INIT_BIT = 2;
  localparam logic [1:0] ACT_NONE    = 2'h0;
  localparam logic [1:0] ACT_LOW     = 2'h1;
  localparam logic [1:0] ACT_HIGH    = 2'h2;
  localparam logic [1:0] ACT_TOGGLE  = 2'h3;

  // ----------------------------------------------------------------
  // Status and mask bits
  // ----------------------------------------------------------------
  localparam int ST_OVF    = 4;
  localparam int ST_UNF    = 5;
  localparam int ST_DIR    = 6;
  localparam int ST_EV_W   = 6;

  // ----------------------------------------------------------------
  // Reset values and prescaler masks
  // ----------------------------------------------------------------
  localparam logic [15:0] CTRL_RESET  = 16'h0000;
  localparam logic [15:0] IOCTL_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] MATCH_RESET = 16'hffff;
  localparam logic [15:0] COUNT_MAX   = 16'hffff;
  localparam logic [PS_DIV_W-1:0] PS_MASK [4] = '{6'h00, 6'h03, 6'h0f, 6'h3f};

  // ----------------------------------------------------------------
  // Channel capabilities, bit n for channel n
  // ----------------------------------------------------------------
  localparam logic [NUM_CH-1:0] PHASE_CAPABLE = 6'h36;
  localparam logic [NUM_CH-1:0] FOUR_MATCH    = 6'h09;
  localparam logic [NUM_CH-1:0] PHASE_ON_CD   = 6'h14;

endpackage

// [rtl/epc_quad_decode.sv]
// Two-phase edge decoder that turns encoder phases into up and down count pulses.
`timescale 1ns/10ps
module epc_quad_decode
  import epc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       phase_a,
  input  wire logic       phase_b,
  input  wire logic [1:0] submode,
  output logic            count_up,
  output logic            count_down
);
  import epc_pkg::*;

  logic prev_a;
  logic prev_b;
  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  // Previous samples; the inputs are already synchronised upstream.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_a <= 1'b0;
      prev_b <= 1'b0;
    end else begin
      prev_a <= phase_a; // R19
      prev_b <= phase_b; // R19
    end
  end

  assign a_rise = phase_a & ~prev_a;
  assign a_fall = ~phase_a & prev_a;
  assign b_rise = phase_b & ~prev_b;
  assign b_fall = ~phase_b & prev_b;

  // ----------------------------------------------------------------
  // Count conditions per sub-mode
  // ----------------------------------------------------------------
  // Both phases changing together is not a legal encoder step; in sub-mode 1 it yields up and down.
  always_comb begin
    count_up   = 1'b0;
    count_down = 1'b0;
    case (submode)
      SUB_PHASE1: begin
        count_up   = (b_rise & phase_a) | (b_fall & ~phase_a) |
                     (a_rise & ~phase_b) | (a_fall & phase_b); // R12
        count_down = (b_fall & phase_a) | (b_rise & ~phase_a) |
                     (a_fall & ~phase_b) | (a_rise & phase_b); // R12
      end
      SUB_PHASE2: begin
        count_up   = a_fall & phase_b; // R13
        count_down = a_fall & ~phase_b; // R13
      end
      SUB_PHASE3: begin
        count_up   = a_fall & phase_b; // R14
        count_down = b_fall & phase_a; // R14
      end
      SUB_PHASE4: begin
        count_up   = (b_rise & phase_a) | (b_fall & ~phase_a); // R15
        count_down = (b_fall & phase_a) | (b_rise & ~phase_a); // R15
      end
      default: begin
        count_up   = 1'b0;
        count_down = 1'b0;
      end
    endcase
  end

endmodule

// [rtl/epc_wave_pin.sv]
// One waveform output pin that changes level on match events.
`timescale 1ns/10ps
module epc_wave_pin
  import epc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       load_init,
  input  wire logic       init_level,
  input  wire logic       match_event,
  input  wire logic [1:0] action,
  output logic            pin_level
);
  import epc_pkg::*;

  // ----------------------------------------------------------------
  // Output level
  // ----------------------------------------------------------------
  // Loading the initial level wins over a match in the same cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_level <= 1'b0;
    end else if (load_init) begin
      pin_level <= init_level;
    end else if (match_event) begin
      case (action)
        ACT_LOW:    pin_level <= 1'b0;
        ACT_HIGH:   pin_level <= 1'b1;
        ACT_TOGGLE: pin_level <= ~pin_level;
        default:    pin_level <= pin_level;
      endcase
    end
  end

endmodule

// [rtl/epc_timer.sv]
// Six-channel 16-bit timer with waveform pins and quadrature counting.
`timescale 1ns/10ps

// Summary of operation
// R1: PWM mode 1 drives pins A and C only; B and D carry no waveform.
// R2: PWM mode 2 maps each match register to its own same-lettered pin.
// R3: PWM mode 2 gives no waveform on the pin of the cycle register.
// R4: Quadrature counting exists only on channels 1, 2, 4 and 5.
// R5: Quadrature mode counts from phase inputs; prescale and edge select ignored.
// R6: Clear source, pin control, interrupt enables and matches keep working there.
// R7: Counting up past the top sets the overflow flag.
// R8: Counting down past zero sets the underflow flag.
// R9: A readable flag shows the present count direction.
// R10: Channels 1,5 use inputs A/B; channels 2,4 use inputs C/D.
// R11: Four quadrature sub-modes, each with its own up/down conditions.
// R12: Sub-mode 1 counts on every edge of both phases.
// R13: Sub-mode 2 counts on A falling; up if B high, else down.
// R14: Sub-mode 3: A falls with B high up; B falls with A high down.
// R15: Sub-mode 4 counts only on B edges, direction from A level.
// R16: PWM mode 1 pins take A/C field levels, then B/D field levels.
// R17: PWM mode 2 cycle clear returns every pin to its initial level.
// R18: Per-channel mode field selects normal, PWM 1, PWM 2 or quadrature 1-4.
// R19: Phase inputs are synchronised and edges found from successive samples.
module epc_timer
  import epc_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic [epc_pkg::ADDR_W-1:0] address,
  input  wire logic                       read,
  input  wire logic                       write,
  input  wire logic [epc_pkg::DATA_W-1:0] writedata,
  input  wire logic [3:0]                 byteenable,
  output logic      [epc_pkg::DATA_W-1:0] readdata,
  output logic                            waitrequest,
  output logic                            irq,
  input  wire logic                       ext_clock_in_a,
  input  wire logic                       ext_clock_in_b,
  input  wire logic                       ext_clock_in_c,
  input  wire logic                       ext_clock_in_d,
  output logic      [epc_pkg::NUM_CH-1:0] waveform_pin_a,
  output logic      [epc_pkg::NUM_CH-1:0] waveform_pin_b,
  output logic      [epc_pkg::NUM_CH-1:0] waveform_pin_c,
  output logic      [epc_pkg::NUM_CH-1:0] waveform_pin_d
);
  import epc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                rst_meta;
  logic                rst_n;
  logic [3:0]          ext_meta;
  logic [3:0]          ext_sync;
  logic                ack;
  logic                wr_fire;
  logic                rd_take;
  logic [2:0]          sel_ch;
  logic [5:0]          sel_ofs;
  logic                sel_ok;
  logic [PS_DIV_W-1:0] ps_div;
  logic [3:0]          ps_tick;
  logic [CNT_W-1:0]    ctrl    [NUM_CH];
  logic [CNT_W-1:0]    ioctl   [NUM_CH];
  logic [CNT_W-1:0]    counter [NUM_CH];
  logic [CNT_W-1:0]    mreg    [NUM_CH][NUM_MR];
  logic [ST_EV_W-1:0]  status  [NUM_CH];
  logic [ST_EV_W-1:0]  mask    [NUM_CH];
  logic [NUM_CH-1:0]   dir_up;
  logic [NUM_CH-1:0]   ch_irq;
  logic [DATA_W-1:0]   ch_rdata [NUM_CH];
  logic [3:0]          pin_lvl  [NUM_CH];

  // Byte-lane merge of a 16-bit register with bus write data.
  function automatic logic [CNT_W-1:0] merge16(input logic [CNT_W-1:0] old_v,
                                               input logic [DATA_W-1:0] new_v,
                                               input logic [3:0] be);
    logic [CNT_W-1:0] r;
    r = old_v;
    if (be[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (be[1]) begin
      r[15:8] = new_v[15:8];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  // Reset asserts at once but releases through two flops.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Phase pins are asynchronous to clk; only the second stage is read by logic.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_meta <= 4'h0;
      ext_sync <= 4'h0;
    end else begin
      ext_meta <= {ext_clock_in_d, ext_clock_in_c, ext_clock_in_b, ext_clock_in_a}; // R19
      ext_sync <= ext_meta; // R19
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait cycle on every access
  // ----------------------------------------------------------------
  assign sel_ch      = address[ADDR_W-1:CH_LSB];
  assign sel_ofs     = address[CH_LSB-1:0];
  assign sel_ok      = (32'(sel_ch) < NUM_CH);
  assign waitrequest = (read | write) & ~ack;
  assign wr_fire     = write & ack;
  assign rd_take     = read & ~ack;

  // The ack flop makes every access take exactly two edges.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (read | write) & ~ack;
    end
  end

  // Read data is registered so it stands stable while waitrequest is low.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= '0;
    end else if (rd_take) begin
      readdata <= sel_ok ? ch_rdata[sel_ch] : '0;
    end
  end

  // ----------------------------------------------------------------
  // Prescaler divider, shared by all channels
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ps_div <= '0;
    end else begin
      ps_div <= ps_div + 1'b1;
    end
  end

  for (genvar p = 0; p < 4; p++) begin : g_ps
    assign ps_tick[p] = ((ps_div & PS_MASK[p]) == '0);
  end

  assign irq = |ch_irq;

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic [2:0]        mode;
    logic [1:0]        clr_sel;
    logic [1:0]        cyc_idx;
    logic              run;
    logic              phase_en;
    logic              q_up;
    logic              q_down;
    logic              up_ev;
    logic              dn_ev;
    logic [NUM_MR-1:0] match;
    logic              cycle_hit;
    logic              ovf_ev;
    logic              unf_ev;
    logic              wr_here;
    logic [ST_EV_W-1:0] events;

    assign mode     = ctrl[c][CTRL_MODE_LSB +: 3]; // R18
    assign clr_sel  = ctrl[c][CTRL_CLR_LSB +: 2];
    assign cyc_idx  = clr_sel - 2'h1;
    assign run      = ctrl[c][CTRL_RUN_BIT];
    assign phase_en = PHASE_CAPABLE[c] & mode[MODE_PHASE_BIT]; // R4
    assign wr_here  = wr_fire & sel_ok & (sel_ch == 3'(c));

    // Quadrature decoder only where the channel supports it.
    if (PHASE_CAPABLE[c]) begin : g_quad
      logic pa;
      logic pb;
      assign pa = PHASE_ON_CD[c] ? ext_sync[2] : ext_sync[0]; // R10
      assign pb = PHASE_ON_CD[c] ? ext_sync[3] : ext_sync[1]; // R10
      epc_quad_decode u_quad (
        .clk        (clk),
        .rst_n      (rst_n),
        .phase_a    (pa),
        .phase_b    (pb),
        .submode    (mode[1:0]),
        .count_up   (q_up),
        .count_down (q_down)
      ); // R11
    end else begin : g_noquad
      assign q_up   = 1'b0;
      assign q_down = 1'b0;
    end

    // In quadrature mode the prescaler is bypassed entirely.
    assign up_ev = run & (phase_en ? q_up : ps_tick[ctrl[c][CTRL_PS_LSB +: 2]]); // R5
    assign dn_ev = run & phase_en & q_down & ~q_up; // R5

    // Match detection stays live in every mode, including quadrature.
    for (genvar k = 0; k < NUM_MR; k++) begin : g_match
      assign match[k] = (up_ev | dn_ev) & (counter[c] == mreg[c][k]) &
                        ((k < 2) | FOUR_MATCH[c]); // R6
    end

    assign cycle_hit = (clr_sel != CLR_NONE) & match[cyc_idx]; // R6
    assign ovf_ev    = up_ev & ~dn_ev & (counter[c] == COUNT_MAX) & ~cycle_hit; // R7
    assign unf_ev    = dn_ev & (counter[c] == '0) & ~cycle_hit; // R8
    assign events    = {unf_ev, ovf_ev, match};

    // Channel counter; a bus write wins over counting in the same cycle.
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        counter[c] <= COUNT_RESET;
      end else if (wr_here && sel_ofs == OFS_COUNT) begin
        counter[c] <= merge16(counter[c], writedata, byteenable);
      end else if (cycle_hit) begin
        counter[c] <= '0;
      end else if (up_ev) begin
        counter[c] <= counter[c] + 1'b1;
      end else if (dn_ev) begin
        counter[c] <= counter[c] - 1'b1;
      end
    end

    // Direction flag follows the last counted step.
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        dir_up[c] <= 1'b1;
      end else if (dn_ev) begin
        dir_up[c] <= 1'b0; // R9
      end else if (up_ev) begin
        dir_up[c] <= 1'b1; // R9
      end
    end

    // Control, pin control, mask and match registers.
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ctrl[c]  <= CTRL_RESET;
        ioctl[c] <= IOCTL_RESET;
        mask[c]  <= '0;
      end else if (wr_here) begin
        if (sel_ofs == OFS_CTRL) begin
          ctrl[c] <= merge16(ctrl[c], writedata, byteenable);
        end
        if (sel_ofs == OFS_IOCTL) begin
          ioctl[c] <= merge16(ioctl[c], writedata, byteenable);
        end
        if (sel_ofs == OFS_MASK && byteenable[0]) begin
          mask[c] <= writedata[ST_EV_W-1:0];
        end
      end
    end

    for (genvar k = 0; k < NUM_MR; k++) begin : g_mreg
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mreg[c][k] <= MATCH_RESET;
        end else if (wr_here && sel_ofs == OFS_MATCH_A + 6'(4 * k) &&
                     ((k < 2) || FOUR_MATCH[c])) begin
          mreg[c][k] <= merge16(mreg[c][k], writedata, byteenable);
        end
      end
    end

    // Sticky status: write one to clear, a new event in the same cycle wins.
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        status[c] <= '0;
      end else begin
        if (wr_here && sel_ofs == OFS_STATUS && byteenable[0]) begin
          status[c] <= (status[c] & ~writedata[ST_EV_W-1:0]) | events; // R7 R8
        end else begin
          status[c] <= status[c] | events; // R7 R8
        end
      end
    end

    assign ch_irq[c] = |(status[c] & mask[c]); // R6

    // Read mux for this channel.
    always_comb begin
      ch_rdata[c] = '0;
      case (sel_ofs)
        OFS_CTRL:    ch_rdata[c] = {16'h0000, ctrl[c]};
        OFS_IOCTL:   ch_rdata[c] = {16'h0000, ioctl[c]};
        OFS_COUNT:   ch_rdata[c] = {16'h0000, counter[c]};
        OFS_MATCH_A: ch_rdata[c] = {16'h0000, mreg[c][0]};
        OFS_MATCH_B: ch_rdata[c] = {16'h0000, mreg[c][1]};
        OFS_MATCH_C: ch_rdata[c] = FOUR_MATCH[c] ? {16'h0000, mreg[c][2]} : '0;
        OFS_MATCH_D: ch_rdata[c] = FOUR_MATCH[c] ? {16'h0000, mreg[c][3]} : '0;
        OFS_STATUS:  ch_rdata[c] = {25'h0, dir_up[c], status[c]}; // R9
        OFS_MASK:    ch_rdata[c] = {26'h0, mask[c]};
        default:     ch_rdata[c] = '0;
      endcase
    end

    // ----------------------------------------------------------------
    // Waveform pins
    // ----------------------------------------------------------------
    for (genvar k = 0; k < NUM_MR; k++) begin : g_pin
      if (k < 2 || FOUR_MATCH[c]) begin : g_has
        logic       pin_ev;
        logic [1:0] pin_act;
        logic       pin_load;

        // Pairs A/B and C/D share one pin in PWM mode 1; equal matches leave it unchanged.
        always_comb begin
          pin_ev  = match[k];
          pin_act = ioctl[c][k * IO_FIELD_W +: 2];
          case (mode)
            MODE_PWM1: begin
              if (k % 2 == 0) begin
                pin_ev  = match[k] ^ match[k | 1]; // R16
                pin_act = match[k] ? ioctl[c][k * IO_FIELD_W +: 2]
                                   : ioctl[c][(k | 1) * IO_FIELD_W +: 2]; // R16
              end else begin
                pin_ev  = 1'b0; // R1
                pin_act = ACT_NONE;
              end
            end
            MODE_PWM2: begin
              pin_ev = match[k] & ~((clr_sel != CLR_NONE) && (cyc_idx == 2'(k))); // R2 R3
            end
            default: begin
              pin_ev = match[k]; // R6
            end
          endcase
        end

        // Writes to the control words reload the initial level; so does a PWM 2 cycle clear.
        assign pin_load = (wr_here && (sel_ofs == OFS_IOCTL || sel_ofs == OFS_CTRL)) ||
                          (mode == MODE_PWM2 && cycle_hit); // R17

        epc_wave_pin u_pin (
          .clk         (clk),
          .rst_n       (rst_n),
          .load_init   (pin_load),
          .init_level  (ioctl[c][k * IO_FIELD_W + IO_INIT_BIT]),
          .match_event (pin_ev),
          .action      (pin_act),
          .pin_level   (pin_lvl[c][k])
        );
      end else begin : g_none
        assign pin_lvl[c][k] = 1'b0;
      end
    end

    assign waveform_pin_a[c] = pin_lvl[c][0];
    assign waveform_pin_b[c] = pin_lvl[c][1];
    assign waveform_pin_c[c] = pin_lvl[c][2];
    assign waveform_pin_d[c] = pin_lvl[c][3];
  end

endmodule

// [sim/epc_timer_chk.sv]
// Assertion checker for the timer bus handshake, interrupt and pin ports.
`timescale 1ns/10ps
module epc_timer_chk
  import epc_pkg::*;
(
  input wire logic                       clk,
  input wire logic                       reset_n,
  input wire logic                       read,
  input wire logic                       write,
  input wire logic                       waitrequest,
  input wire logic                       irq,
  input wire logic [epc_pkg::DATA_W-1:0] readdata,
  input wire logic [epc_pkg::NUM_CH-1:0] waveform_pin_c,
  input wire logic [epc_pkg::NUM_CH-1:0] waveform_pin_d
);
  // ----
  // Properties
  // ----
  // One domain only, so clock and reset are given once for all of them.
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_PIN_C_LIMIT: assert property ((waveform_pin_c & ~FOUR_MATCH) == 6'h00)
    else $error("pin c driven on a two-match channel");
  AST_PIN_D_LIMIT: assert property ((waveform_pin_d & ~FOUR_MATCH) == 6'h00)
    else $error("pin d driven on a two-match channel");
  AST_IDLE_NOWAIT: assert property (!(read || write) |-> !waitrequest)
    else $error("wait raised with no request");
  AST_FIRST_WAIT: assert property ((read || write) && !$past(read || write) |-> waitrequest)
    else $error("no wait in first access cycle");
  AST_ONE_WAIT: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("access took more than one wait");
  AST_BACK_WAIT: assert property (write && !waitrequest |=> !write || waitrequest)
    else $error("next access taken without a wait");
  AST_RDATA_HOLD: assert property (!read |=> $stable(readdata))
    else $error("read data moved without a read");
  AST_IRQ_HOLD: assert property (irq && !(write && !waitrequest) |=> irq)
    else $error("interrupt dropped without a write");
  cover property (irq);
  cover property (read && !waitrequest);
  cover property (write && !waitrequest);
endmodule

bind epc_timer epc_timer_chk chk_u (.clk(clk), .reset_n(reset_n), .read(read), .write(write),
  .waitrequest(waitrequest), .irq(irq), .readdata(readdata),
  .waveform_pin_c(waveform_pin_c), .waveform_pin_d(waveform_pin_d));

// [sim/epc_encoder_model.sv]
// Two-phase encoder model that steps its phases one edge at a time.
`timescale 1ns/10ps
module epc_encoder_model (
  input  wire logic clk,
  input  wire logic step,
  input  wire logic step_up,
  input  wire logic sel_cd,
  output logic      ph_a,
  output logic      ph_b,
  output logic      ph_c,
  output logic      ph_d
);
  logic [1:0] q;
  logic [1:0] nq;
  initial begin
    q = 2'h0;
    {ph_a, ph_b, ph_c, ph_d} = 4'h0;
  end
  // Up order of {a,b} is 00,10,11,01; one edge per step, so phases never move together.
  always @(posedge clk) begin
    if (step) begin
      nq = step_up ? {~q[0], q[1]} : {q[0], ~q[1]};
      q <= nq;
      if (sel_cd) {ph_c, ph_d} <= nq;
      else {ph_a, ph_b} <= nq;
    end
  end
endmodule

// [sim/epc_timer_bench.sv]
// Self-checking bench for bus access, quadrature counting and count flags.
`timescale 1ns/10ps
module epc_timer_bench;
  import epc_pkg::*;
  logic              clk;
  logic              reset_n;
  logic [ADDR_W-1:0] address;
  logic              read;
  logic              write;
  logic [DATA_W-1:0] writedata;
  logic [DATA_W-1:0] readdata;
  logic [DATA_W-1:0] rd;
  logic              waitrequest;
  logic              irq;
  logic              step;
  logic              step_up;
  logic              sel_cd;
  logic              ca, cb, cc, cd;
  logic [NUM_CH-1:0] pa, pb, pc, pd;
  int                failures;
  int                n_compared;
  int                cyc;
  epc_timer dut_u (.clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'h3), .readdata(readdata), .waitrequest(waitrequest),
    .irq(irq), .ext_clock_in_a(ca), .ext_clock_in_b(cb), .ext_clock_in_c(cc),
    .ext_clock_in_d(cd), .waveform_pin_a(pa), .waveform_pin_b(pb), .waveform_pin_c(pc),
    .waveform_pin_d(pd));
  epc_encoder_model enc_u (.clk(clk), .step(step), .step_up(step_up), .sel_cd(sel_cd),
    .ph_a(ca), .ph_b(cb), .ph_c(cc), .ph_d(cd));
  // ----
  // Shared tasks
  // ----
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // The request holds until an edge samples wait low; read data is taken there.
  task automatic bus(input logic wr, input logic [2:0] ch, input logic [5:0] ofs,
                     input logic [15:0] d);
    @(posedge clk);
    address <= {ch, ofs};
    writedata <= {16'h0000, d};
    read <= ~wr;
    write <= wr;
    do @(posedge clk); while (waitrequest);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [2:0] ch, input logic [5:0] ofs,
                      input logic [15:0] exp);
    bus(1'b0, ch, ofs, 16'h0000);
    chk(what, rd, {16'h0000, exp});
  endtask
  // Steps are four cycles apart, well over the two-cycle minimum between phase edges.
  task automatic turn(input logic up, input int n);
    repeat (n) begin
      @(posedge clk);
      step <= 1'b1;
      step_up <= up;
      @(posedge clk);
      step <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    rchk("match a reset", 3'h0, OFS_MATCH_A, MATCH_RESET);
    rchk("status reset", 3'h1, OFS_STATUS, 16'h0040);
    rchk("match c two-match ch", 3'h1, OFS_MATCH_C, 16'h0000);
    $display("test reset done");
  endtask
  // Channels 1 and 2 alternate so both input pairs are used; prescale is set to /64.
  task automatic t_phase;
    logic [2:0]  ch;
    logic [15:0] k;
    for (int m = 0; m < 4; m++) begin
      ch = m[0] ? 3'h2 : 3'h1;
      k = (m == 0) ? 16'h0004 : (m == 3) ? 16'h0002 : 16'h0001;
      @(posedge clk);
      sel_cd <= m[0];
      bus(1'b1, ch, OFS_CTRL, 16'h8304 | 16'(m));
      bus(1'b1, ch, OFS_COUNT, 16'h0010);
      turn(1'b1, 4);
      rchk("count up", ch, OFS_COUNT, 16'h0010 + k);
      rchk("dir up", ch, OFS_STATUS, 16'h0040);
      turn(1'b0, 4);
      rchk("count down", ch, OFS_COUNT, 16'h0010);
      rchk("dir down", ch, OFS_STATUS, 16'h0000);
    end
    $display("test phase done");
  endtask
  task automatic t_flags;
    @(posedge clk);
    sel_cd <= 1'b0;
    bus(1'b1, 3'h1, OFS_CTRL, 16'h8004);
    bus(1'b1, 3'h1, OFS_MASK, 16'h0020);
    bus(1'b1, 3'h1, OFS_COUNT, 16'h0000);
    turn(1'b0, 1);
    @(negedge clk);
    chk("irq set", {31'h0, irq}, 32'h1);
    rchk("wrap down", 3'h1, OFS_COUNT, 16'hffff);
    rchk("underflow", 3'h1, OFS_STATUS, 16'h0020);
    bus(1'b1, 3'h1, OFS_STATUS, 16'h0020);
    @(negedge clk);
    chk("irq clear", {31'h0, irq}, 32'h0);
    bus(1'b1, 3'h1, OFS_IOCTL, 16'h0032);
    turn(1'b1, 1);
    chk("pins a b", {30'h0, pa[1], pb[1]}, 32'h3);
    rchk("wrap up", 3'h1, OFS_COUNT, 16'h0000);
    rchk("overflow", 3'h1, OFS_STATUS, 16'h0053);
    $display("test flags done");
  endtask
  // A hang is cut short after far more cycles than the scenarios need.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      close_out;
    end
  end
  initial begin
    {reset_n, read, write, step, step_up, sel_cd} = 6'h00;
    address = '0;
    writedata = '0;
    failures = 0;
    n_compared = 0;
    cyc = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_phase;
    t_flags;
    close_out;
  end
endmodule
